// ==== hdl/flash_access_pkg.sv ====
// Purpose: Shared constants and types of the block-access engine
// Assumes: One word per command location, byte address is four times the index
// Notes:   Slot numbers and key layout are shared by both design files
package flash_access_pkg;
	// ----------------------------------------------------------------
	// Command locations (indices)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CTRL      = 8'h00;
	localparam logic [7:0] IDX_STATUS    = 8'h01;
	localparam logic [7:0] IDX_SUBCLASS  = 8'h3E;
	localparam logic [7:0] IDX_BLKSEL    = 8'h3F;
	localparam logic [7:0] IDX_BUF_FIRST = 8'h40;
	localparam logic [7:0] IDX_BUF_LAST  = 8'h5F;
	localparam logic [7:0] IDX_CHK       = 8'h60;
	localparam logic [7:0] IDX_ASEL      = 8'h61;
	localparam logic [7:0] IDX_NONE      = 8'hFF;
	// ----------------------------------------------------------------
	// Field values and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  ASEL_GENERAL    = 8'h00;
	localparam logic [7:0]  ASEL_RST        = 8'h00;
	localparam logic [7:0]  SUBCLASS_RST    = 8'h00;
	localparam logic [7:0]  BLKSEL_RST      = 8'h00;
	localparam logic [7:0]  INFO_SEL_A      = 8'h01;
	localparam logic [7:0]  INFO_SEL_B      = 8'h02;
	localparam logic [7:0]  INFO_B_SUBCLASS = 8'h3A;
	localparam logic [7:0]  INFO_B_BLOCK    = 8'h01;
	localparam logic [7:0]  KEY_SUBCLASS    = 8'h70;
	localparam logic [7:0]  CHK_BASE        = 8'hFF;
	localparam logic [5:0]  BLOCK_BYTES     = 6'h20;
	localparam logic [15:0] SEAL_CMD        = 16'h0020;
	localparam int          STAT_SEALED     = 0;
	localparam int          STAT_FULLFLAG   = 1;
	localparam int          STAT_OVF        = 2;
	localparam int          STAT_COMMIT_OK  = 3;
	// ----------------------------------------------------------------
	// Storage slots
	// ----------------------------------------------------------------
	localparam int          NSLOT      = 11;
	localparam int          SLOT_W     = 4;
	localparam int          BLOCK_BITS = 256;
	localparam logic [3:0]  SLOT_A     = 4'h0;
	localparam logic [3:0]  SLOT_B     = 4'h1;
	localparam logic [3:0]  SLOT_KEY   = 4'h2;
	localparam logic [3:0]  SLOT_GEN0  = 4'h3;
	// Key slot bytes 0..3 hold the unseal key, bytes 4..7 the full-access key
	localparam logic [31:0] DEF_UNSEAL_KEY = 32'h36720414;
	localparam logic [31:0] DEF_FULL_KEY   = 32'hFFFFFFFF;
	// ----------------------------------------------------------------
	// Security mode, Gray along sealed-unsealed-full
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SEC_SEALED   = 2'h0,
		SEC_UNSEALED = 2'h1,
		SEC_FULL     = 2'h3
	} sec_mode_t;
	localparam sec_mode_t SEC_RST = SEC_SEALED;
endpackage : flash_access_pkg

// ==== hdl/store_if.sv ====
// Purpose: Link between the access engine and the persistent block store
// Assumes: Read is combinational from the store's flip-flops
// Notes:   Write is a one-cycle strobe with a whole block
`timescale 1ns/1ps
interface store_if;
	logic                                      wr_en;
	logic [flash_access_pkg::SLOT_W-1:0]       wr_slot;
	logic [flash_access_pkg::BLOCK_BITS-1:0]   wr_data;
	logic [flash_access_pkg::SLOT_W-1:0]       rd_slot;
	logic [flash_access_pkg::BLOCK_BITS-1:0]   rd_data;
	logic [63:0]                               key_data;
	modport ctrl (output wr_en, wr_slot, wr_data, rd_slot, input rd_data, key_data);
	modport mem  (input wr_en, wr_slot, wr_data, rd_slot, output rd_data, key_data);
endinterface : store_if

// ==== hdl/flash_store.sv ====
// Purpose: Persistent block store, one slot per 32-byte block
// Assumes: Contents survive the block reset; power-up image is fixed
// Notes:   No reset input on purpose, a reset must not restore contents
`timescale 1ns/1ps
module flash_store (
	input  wire logic i_ref_clk,
	store_if.mem      store
);
	typedef struct packed {
		logic [flash_access_pkg::NSLOT-1:0][flash_access_pkg::BLOCK_BITS-1:0] slot;
	} mem_t;

	function automatic mem_t init_mem();
		mem_t m;
		m = '0;
		m.slot[flash_access_pkg::SLOT_KEY][31:0]  = flash_access_pkg::DEF_UNSEAL_KEY;
		m.slot[flash_access_pkg::SLOT_KEY][63:32] = flash_access_pkg::DEF_FULL_KEY;
		return m;
	endfunction : init_mem

	mem_t state_reg = init_mem();
	mem_t state_next;

	always_comb
	begin
		state_next = state_reg;
		if (store.wr_en)
		begin
			state_next.slot[store.wr_slot] = store.wr_data;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		state_reg <= state_next;
	end

	assign store.rd_data  = state_reg.slot[store.rd_slot];
	assign store.key_data = state_reg.slot[flash_access_pkg::SLOT_KEY][63:0];
endmodule : flash_store

// ==== hdl/flash_block_access.sv ====
// Purpose: Block buffer, checksum commit and key-driven security modes
// Assumes: AHB-Lite slave, single word transfers, only low byte/word used
// Notes:   Reads take one wait state so a preceding write is always visible
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module flash_block_access (
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hwdata,
	output logic      [31:0] o_hrdata,
	output logic             o_hreadyout,
	output logic             o_hresp
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		flash_access_pkg::sec_mode_t sec;
		logic                        key_pend;
		logic                        pend_full;
		logic [31:0][7:0]            blk_buf;
		logic [7:0]                  chk;
		logic [7:0]                  asel;
		logic [7:0]                  subclass;
		logic [7:0]                  blksel;
		logic [3:0]                  slot;
		logic                        slot_ok;
		logic [5:0]                  wcount;
		logic                        ovf;
		logic                        commit_ok;
		logic                        ph_wr;
		logic                        ph_rd;
		logic                        rd_wait;
		logic [7:0]                  ph_idx;
		logic [31:0]                 rdata;
	} state_t;
	localparam state_t ST_RST = '{
		sec:      flash_access_pkg::SEC_RST,
		asel:     flash_access_pkg::ASEL_RST,
		subclass: flash_access_pkg::SUBCLASS_RST,
		blksel:   flash_access_pkg::BLKSEL_RST,
		default:  '0
	};
	state_t  st_reg;
	state_t  st_next;
	store_if store ();
	flash_store u_store (
		.i_ref_clk (i_ref_clk),
		.store     (store.mem)
	);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] sum_bytes(input logic [31:0][7:0] b);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 32; i++)
		begin
			s = s + b[i];
		end
		return s;
	endfunction : sum_bytes
	function automatic logic [15:0] swap16(input logic [15:0] w);
		return {w[7:0], w[15:8]};
	endfunction : swap16
	// Returns {valid, slot}; general slots fold subclass and block low bits
	function automatic logic [4:0] resolve(input logic gen, input logic [7:0] sub,
		input logic [7:0] blk);
		logic [4:0] r;
		r = 5'h00;
		if (gen)
		begin
			if (sub == flash_access_pkg::INFO_B_SUBCLASS && blk == flash_access_pkg::INFO_B_BLOCK)
				r = {1'b1, flash_access_pkg::SLOT_B};
			else if (sub == flash_access_pkg::KEY_SUBCLASS && blk == 8'h00)
				r = {1'b1, flash_access_pkg::SLOT_KEY};
			else
				r = {1'b1, flash_access_pkg::SLOT_GEN0 + {1'b0, sub[1:0], blk[0]}};
		end
		else if (blk == flash_access_pkg::INFO_SEL_A)
			r = {1'b1, flash_access_pkg::SLOT_A};
		else if (blk == flash_access_pkg::INFO_SEL_B)
			r = {1'b1, flash_access_pkg::SLOT_B};
		return r;
	endfunction : resolve
	// Write permission per mode and slot
	function automatic logic may_write(input flash_access_pkg::sec_mode_t m,
		input logic [3:0] s);
		logic ok;
		ok = 1'b1;
		if (s == flash_access_pkg::SLOT_KEY)
			ok = (m == flash_access_pkg::SEC_FULL);
		else if (m == flash_access_pkg::SEC_SEALED)
			ok = (s == flash_access_pkg::SLOT_B);
		return ok;
	endfunction : may_write
	function automatic logic [31:0] read_mux(input state_t s);
		logic [31:0] d;
		d = 32'h00000000;
		if (s.ph_idx >= flash_access_pkg::IDX_BUF_FIRST && s.ph_idx <= flash_access_pkg::IDX_BUF_LAST)
			d[7:0] = s.blk_buf[s.ph_idx[4:0]];
		else
		begin
			case (s.ph_idx)
				flash_access_pkg::IDX_CHK:      d[7:0] = s.chk;
				flash_access_pkg::IDX_ASEL:     d[7:0] = s.asel;
				flash_access_pkg::IDX_SUBCLASS: d[7:0] = s.subclass;
				flash_access_pkg::IDX_BLKSEL:   d[7:0] = s.blksel;
				flash_access_pkg::IDX_STATUS:
				begin
					d[flash_access_pkg::STAT_SEALED]    = (s.sec == flash_access_pkg::SEC_SEALED);
					d[flash_access_pkg::STAT_FULLFLAG]  = (s.sec != flash_access_pkg::SEC_FULL);
					d[flash_access_pkg::STAT_OVF]       = s.ovf;
					d[flash_access_pkg::STAT_COMMIT_OK] = s.commit_ok;
				end
				default:                        d = 32'h00000000;
			endcase
		end
		return d;
	endfunction : read_mux
	// ----------------------------------------------------------------
	// Data-phase decode
	// ----------------------------------------------------------------
	logic        wr_sub;
	logic        wr_blk;
	logic        wr_asel;
	logic        wr_chk;
	logic        wr_ctrl;
	logic        wr_buf;
	logic [7:0]  new_sub;
	logic [7:0]  new_blk;
	logic [7:0]  new_asel;
	logic        general;
	logic        load_req;
	logic [4:0]  res;
	logic        chk_match;
	logic        commit;
	logic [15:0] key_first;
	logic [15:0] key_second;
	logic [7:0]  a_idx;
	assign wr_sub   = st_reg.ph_wr && st_reg.ph_idx == flash_access_pkg::IDX_SUBCLASS;
	assign wr_blk   = st_reg.ph_wr && st_reg.ph_idx == flash_access_pkg::IDX_BLKSEL;
	// Access select is not available while sealed
	assign wr_asel  = st_reg.ph_wr && st_reg.ph_idx == flash_access_pkg::IDX_ASEL
		&& st_reg.sec != flash_access_pkg::SEC_SEALED;
	assign wr_chk   = st_reg.ph_wr && st_reg.ph_idx == flash_access_pkg::IDX_CHK;
	assign wr_ctrl  = st_reg.ph_wr && st_reg.ph_idx == flash_access_pkg::IDX_CTRL;
	assign wr_buf   = st_reg.ph_wr && st_reg.ph_idx >= flash_access_pkg::IDX_BUF_FIRST
		&& st_reg.ph_idx <= flash_access_pkg::IDX_BUF_LAST;
	assign new_sub  = wr_sub ? i_hwdata[7:0] : st_reg.subclass;
	assign new_blk  = wr_blk ? i_hwdata[7:0] : st_reg.blksel;
	assign new_asel = wr_asel ? i_hwdata[7:0] : st_reg.asel;
	assign general  = st_reg.sec != flash_access_pkg::SEC_SEALED
		&& new_asel == flash_access_pkg::ASEL_GENERAL;
	assign load_req = wr_asel || wr_blk;
	assign res      = resolve(general, new_sub, new_blk);
	// Sum is over the buffer as it stands, not over storage
	assign chk_match = wr_chk && i_hwdata[7:0] == flash_access_pkg::CHK_BASE - sum_bytes(st_reg.blk_buf);
	// No range check on contents, only checksum, length, slot validity and permission
	assign commit   = chk_match && st_reg.slot_ok && !st_reg.ovf
		&& may_write(st_reg.sec, st_reg.slot);
	assign key_first  = swap16(st_reg.sec == flash_access_pkg::SEC_SEALED ?
		store.key_data[15:0] : store.key_data[47:32]);
	assign key_second = swap16(st_reg.pend_full ? store.key_data[63:48] : store.key_data[31:16]);
	assign a_idx = (i_haddr[31:10] == 22'h000000) ? i_haddr[9:2] : flash_access_pkg::IDX_NONE;
	assign store.rd_slot = res[3:0];
	assign store.wr_en   = commit;
	assign store.wr_slot = st_reg.slot;
	assign store.wr_data = st_reg.blk_buf;
	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		st_next = st_reg;
		if (st_reg.ph_rd && !st_reg.rd_wait)
		begin
			st_next.rd_wait = 1'b1;
			st_next.rdata   = read_mux(st_reg);
		end
		if (i_hready)
		begin
			st_next.ph_wr   = i_hsel && i_htrans[1] && i_hwrite;
			st_next.ph_rd   = i_hsel && i_htrans[1] && !i_hwrite;
			st_next.rd_wait = 1'b0;
			st_next.ph_idx  = a_idx;
		end
		if (wr_sub)
			st_next.subclass = i_hwdata[7:0];
		if (wr_blk)
			st_next.blksel = i_hwdata[7:0];
		if (wr_asel)
			st_next.asel = i_hwdata[7:0];
		if (load_req)
		begin
			st_next.slot    = res[3:0];
			st_next.slot_ok = res[4];
			st_next.wcount  = 6'h00;
			st_next.ovf     = 1'b0;
			if (res[4])
			begin
				st_next.blk_buf = store.rd_data;
				st_next.chk     = flash_access_pkg::CHK_BASE - sum_bytes(store.rd_data);
			end
		end
		if (wr_buf)
		begin
			if (st_reg.wcount == flash_access_pkg::BLOCK_BYTES)
				st_next.ovf = 1'b1;
			else
			begin
				st_next.blk_buf[st_reg.ph_idx[4:0]] = i_hwdata[7:0];
				st_next.wcount = st_reg.wcount + 6'h01;
			end
		end
		if (wr_chk)
		begin
			st_next.chk       = i_hwdata[7:0];
			st_next.commit_ok = commit;
		end
		if (wr_ctrl)
		begin
			st_next.key_pend = 1'b0;
			if (st_reg.key_pend)
			begin
				if (i_hwdata[15:0] == key_second)
				begin
					case (st_reg.sec)
						flash_access_pkg::SEC_SEALED:   st_next.sec = flash_access_pkg::SEC_UNSEALED;
						flash_access_pkg::SEC_UNSEALED: st_next.sec = flash_access_pkg::SEC_FULL;
						default:                        st_next.sec = st_reg.sec;
					endcase
				end
			end
			else if (i_hwdata[15:0] == flash_access_pkg::SEAL_CMD)
				st_next.sec = flash_access_pkg::SEC_SEALED;
			else if (i_hwdata[15:0] == key_first && st_reg.sec != flash_access_pkg::SEC_FULL)
			begin
				st_next.key_pend  = 1'b1;
				st_next.pend_full = (st_reg.sec == flash_access_pkg::SEC_UNSEALED);
			end
		end
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			st_reg <= ST_RST;
		else
			st_reg <= st_next;
	end
	// Reads stall one cycle; writes are zero wait
	assign o_hreadyout = !(st_reg.ph_rd && !st_reg.rd_wait);
	assign o_hrdata    = st_reg.rdata;
	assign o_hresp     = 1'b0;
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	a_load_general: assert property (
		wr_asel && i_hwdata[7:0] == flash_access_pkg::ASEL_GENERAL
		|=> st_reg.slot_ok && st_reg.blk_buf == $past(store.rd_data))
		else $error("general block not loaded");
	a_commit_checked: assert property (
		store.wr_en |-> wr_chk && i_hwdata[7:0] == flash_access_pkg::CHK_BASE - sum_bytes(st_reg.blk_buf))
		else $error("storage written without matching checksum");
	a_byte_write: assert property (
		wr_buf && st_reg.wcount != flash_access_pkg::BLOCK_BYTES
		|=> st_reg.blk_buf[$past(st_reg.ph_idx[4:0])] == $past(i_hwdata[7:0]))
		else $error("buffer byte not stored");
	a_length_limit: assert property (
		wr_buf && st_reg.wcount == flash_access_pkg::BLOCK_BYTES
		|=> st_reg.ovf && !store.wr_en)
		else $error("overlong block not ignored");
	a_info_b_map: assert property (
		load_req && general && new_sub == flash_access_pkg::INFO_B_SUBCLASS
		&& new_blk == flash_access_pkg::INFO_B_BLOCK
		|=> st_reg.slot == flash_access_pkg::SLOT_B && st_reg.slot_ok)
		else $error("subclass 58 block 1 not mapped to info B");
	a_info_select: assert property (
		load_req && !general && new_blk == flash_access_pkg::INFO_SEL_A
		|=> st_reg.slot == flash_access_pkg::SLOT_A && st_reg.slot_ok)
		else $error("info block A not selected");
	a_sealed_access: assert property (
		store.wr_en && st_reg.sec == flash_access_pkg::SEC_SEALED
		|-> store.wr_slot == flash_access_pkg::SLOT_B)
		else $error("sealed write outside info B");
	a_key_update: assert property (
		store.wr_en && store.wr_slot == flash_access_pkg::SLOT_KEY
		|-> st_reg.sec == flash_access_pkg::SEC_FULL)
		else $error("keys written outside full access");
	a_pair_broken: assert property (
		wr_ctrl && st_reg.key_pend && i_hwdata[15:0] != key_second
		|=> st_reg.sec == $past(st_reg.sec) && !st_reg.key_pend)
		else $error("broken key pair changed mode");
	a_unseal_pair: assert property (
		wr_ctrl && st_reg.key_pend && i_hwdata[15:0] == key_second
		&& st_reg.sec == flash_access_pkg::SEC_SEALED
		|=> st_reg.sec == flash_access_pkg::SEC_UNSEALED)
		else $error("valid unseal pair ignored");
	a_bad_chk_keeps: assert property (
		wr_chk && !chk_match |=> st_reg.sec == $past(st_reg.sec) && !st_reg.commit_ok)
		else $error("bad checksum had an effect");

	c_commit: cover property (store.wr_en);
	c_unseal: cover property (st_reg.sec == flash_access_pkg::SEC_SEALED
		##1 st_reg.sec == flash_access_pkg::SEC_UNSEALED);
	c_full: cover property (st_reg.sec == flash_access_pkg::SEC_UNSEALED
		##1 st_reg.sec == flash_access_pkg::SEC_FULL);
	c_overflow: cover property (st_reg.ovf);
endmodule : flash_block_access

// ==== test/ahb_host_model.sv ====
// Purpose: AHB-Lite host issuing single whole-word transfers
// Assumes: One slave, whose hreadyout is the bus hready
// Notes:   Waits on hready with no bound; the bench watchdog cuts a hang
`timescale 1ns/1ps
module ahb_host_model (
	input  wire logic        i_ref_clk,
	input  wire logic        i_hready,
	input  wire logic [31:0] i_hrdata,
	output logic             o_hsel,
	output logic      [31:0] o_haddr,
	output logic      [1:0]  o_htrans,
	output logic             o_hwrite,
	output logic      [2:0]  o_hsize,
	output logic      [31:0] o_hwdata
);
	initial
	begin
		o_hsel   = 1'b0;
		o_haddr  = 32'h00000000;
		o_htrans = 2'h0;
		o_hwrite = 1'b0;
		o_hsize  = 3'h2;
		o_hwdata = 32'h00000000;
	end
	// ----------------------------------------------------------------
	// Transfer task
	// ----------------------------------------------------------------
	// Caller stands at a rising edge; returns at the edge ending the data phase
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		o_hsel   <= 1'b1;
		o_haddr  <= {22'h000000, idx, 2'h0};
		o_htrans <= 2'h2;
		o_hwrite <= wr;
		do @(posedge i_ref_clk); while (i_hready !== 1'b1);
		o_htrans <= 2'h0;
		o_hwdata <= wd;
		do @(posedge i_ref_clk); while (i_hready !== 1'b1);
		rd = i_hrdata;
	endtask : xfer
endmodule : ahb_host_model

// ==== test/flash_block_access_tb_top.sv ====
// Purpose: Self-checking bench of block buffer, commit and security modes
// Assumes: Power-up store is zero except the default keys
// Notes:   Key slot is rewritten last, so later unseals would fail
`timescale 1ns/1ps
module flash_block_access_tb_top;
	localparam logic [7:0] CTL = flash_access_pkg::IDX_CTRL;
	localparam logic [7:0] STA = flash_access_pkg::IDX_STATUS;
	localparam logic [7:0] SUB = flash_access_pkg::IDX_SUBCLASS;
	localparam logic [7:0] BSL = flash_access_pkg::IDX_BLKSEL;
	localparam logic [7:0] BUF = flash_access_pkg::IDX_BUF_FIRST;
	localparam logic [7:0] CHK = flash_access_pkg::IDX_CHK;
	localparam logic [7:0] ASL = flash_access_pkg::IDX_ASEL;
	logic        ref_clk;
	logic        rst_b;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [7:0]  buf_img [32];
	int          miscompares;
	int          compares;

	flash_block_access uut (.i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hready(hreadyout), .i_hwdata(hwdata), .o_hrdata(hrdata),
		.o_hreadyout(hreadyout), .o_hresp(hresp));
	ahb_host_model host (.i_ref_clk(ref_clk), .i_hready(hreadyout), .i_hrdata(hrdata),
		.o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
		.o_hsize(hsize), .o_hwdata(hwdata));

	always #5 ref_clk = ~ref_clk;
	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] unused;
		host.xfer(1'b1, idx, d, unused);
	endtask : wr
	task automatic chk(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] got;
		host.xfer(1'b0, idx, 32'h00000000, got);
		compares++;
		if (((got & mask) !== exp) || (hresp !== 1'b0))
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got & mask, exp);
		end
	endtask : chk
	function automatic logic [7:0] csum();
		logic [7:0] s;
		s = 8'h00;
		foreach (buf_img[i]) s += buf_img[i];
		return 8'hFF - s;
	endfunction : csum
	// Bad checksum is the good one inverted, so it can never match by chance
	task automatic fill(input logic [7:0] base, input logic good);
		for (int i = 0; i < 32; i++)
		begin
			buf_img[i] = base + 8'(i);
			wr(BUF + 8'(i), {24'h000000, buf_img[i]});
		end
		wr(CHK, {24'h000000, good ? csum() : ~csum()});
	endtask : fill
	task automatic send_key(input logic [31:0] key);
		wr(CTL, {16'h0000, key[7:0], key[15:8]});
		wr(CTL, {16'h0000, key[23:16], key[31:24]});
	endtask : send_key
	task automatic print_verdict();
		$display("Comparisons %0d, miscompares %0d", compares, miscompares);
		if ((miscompares == 0) && (compares > 0))
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	// ----------------------------------------------------------------
	// Watchdog
	// ----------------------------------------------------------------
	initial
	begin
		#100000;
		miscompares++;
		print_verdict();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk(STA, 32'h3, 32'h3);
		// Access select is closed while sealed
		wr(ASL, 32'h5);
		chk(ASL, 32'hFF, 32'h0);
		wr(BSL, 32'h2);
		fill(8'hA0, 1'b1);
		chk(STA, 32'h8, 32'h8);
		wr(BSL, 32'h1);
		chk(BUF + 8'h3, 32'hFF, 32'h0);
		fill(8'h30, 1'b1);
		chk(STA, 32'h8, 32'h0);
		wr(BSL, 32'h1);
		chk(BUF + 8'h3, 32'hFF, 32'h0);
		wr(BSL, 32'h2);
		chk(BUF + 8'h3, 32'hFF, 32'hA3);
		// Pair broken by a foreign control word, then a wrong pair
		wr(CTL, 32'h00001404);
		wr(CTL, 32'h00000001);
		wr(CTL, 32'h00007236);
		chk(STA, 32'h3, 32'h3);
		send_key(32'h12345678);
		chk(STA, 32'h3, 32'h3);
		send_key(flash_access_pkg::DEF_UNSEAL_KEY);
		chk(STA, 32'h3, 32'h2);
		// Info mode while unsealed: B readable, A writable
		wr(ASL, 32'h1);
		chk(ASL, 32'hFF, 32'h1);
		wr(BSL, 32'h2);
		chk(BUF + 8'h3, 32'hFF, 32'hA3);
		wr(BSL, 32'h1);
		fill(8'h30, 1'b1);
		chk(STA, 32'h8, 32'h8);
		wr(BSL, 32'h1);
		chk(BUF + 8'h3, 32'hFF, 32'h33);
		wr(ASL, 32'h0);
		wr(SUB, 32'h3A);
		wr(BSL, 32'h1);
		chk(BUF + 8'h5, 32'hFF, 32'hA5);
		// Offset 33 of subclass 2 sits in block 1 at byte 1
		wr(SUB, 32'h2);
		wr(BSL, 32'(33 / 32));
		fill(8'hF0, 1'b0);
		chk(STA, 32'hB, 32'h2);
		wr(ASL, 32'h0);
		chk(BUF + 8'(33 % 32), 32'hFF, 32'h0);
		fill(8'hF0, 1'b1);
		chk(STA, 32'h8, 32'h8);
		wr(ASL, 32'h0);
		chk(BUF + 8'(33 % 32), 32'hFF, 32'hF1);
		buf_img[2] = 8'h5A;
		wr(BUF + 8'h2, 32'h5A);
		wr(CHK, {24'h000000, csum()});
		wr(ASL, 32'h0);
		chk(BUF + 8'h2, 32'hFF, 32'h5A);
		chk(BUF + 8'h3, 32'hFF, 32'hF3);
		// One write past the block must void the commit
		for (int i = 0; i < 33; i++) wr(BUF + 8'(i % 32), 32'h55);
		foreach (buf_img[i]) buf_img[i] = 8'h55;
		wr(CHK, {24'h000000, csum()});
		chk(STA, 32'hC, 32'h4);
		wr(ASL, 32'h0);
		chk(BUF + 8'h2, 32'hFF, 32'h5A);
		wr(8'h70, 32'hFF);
		chk(8'h70, 32'hFFFFFFFF, 32'h0);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		chk(STA, 32'h3, 32'h3);
		wr(BSL, 32'h2);
		chk(BUF + 8'h3, 32'hFF, 32'hA3);
		send_key(flash_access_pkg::DEF_UNSEAL_KEY);
		wr(SUB, {24'h000000, flash_access_pkg::KEY_SUBCLASS});
		wr(BSL, 32'h0);
		fill(8'h40, 1'b1);
		chk(STA, 32'h8, 32'h0);
		send_key(flash_access_pkg::DEF_FULL_KEY);
		chk(STA, 32'h3, 32'h0);
		wr(BSL, 32'h0);
		fill(8'h40, 1'b1);
		chk(STA, 32'h8, 32'h8);
		wr(BSL, 32'h0);
		chk(BUF + 8'h7, 32'hFF, 32'h47);
		wr(CTL, {16'h0000, flash_access_pkg::SEAL_CMD});
		chk(STA, 32'h1, 32'h1);
		print_verdict();
	end
endmodule : flash_block_access_tb_top
